// >>> design/cwcs_config_word.sv
`timescale 1ns/1ps
`include "cwcs_defs.svh"
module cwcs_config_word
    import cwcs_pkg::*;
#(
    parameter int ERASE_CYC = `CWCS_ERASE_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic prog_mode,
    input wire logic [13:0] prog_addr,
    input wire logic [13:0] prog_wdata,
    input wire logic prog_wr,
    input wire logic prog_rd,
    output logic [13:0] prog_rdata,
    output logic prog_rvalid,
    output logic prog_busy,
    input wire logic core_cfg_access,
    output logic core_cfg_denied,
    input wire logic sw_trim_wr,
    input wire logic [7:0] sw_trim_data,
    output logic [7:0] osc_trim_reg,
    output logic erase_data_array,
    output logic erase_program_array,
    input wire logic master_reset_pin_n,
    output logic reset_pin_as_io,
    output logic core_reset_n,
    output logic [1:0] bandgap_trim,
    output logic data_protect_n,
    output logic program_protect_n,
    output logic brownout_detect_en,
    output logic powerup_timer_en,
    output logic watchdog_en,
    output logic [2:0] osc_select,
    output logic [1:0] clk_source,
    output logic internal_rc_osc_run,
    output logic osc_in_pin_as_io,
    output logic osc_out_pin_as_io,
    output logic osc_out_clk_en,
    output logic quarter_clock_out
);
    // Blank parts ship erased, so every bit starts unprogrammed
    logic [13:0] cfg_q = `CWCS_CFG_ERASED;
    logic [13:0] cfg_d;
    logic [13:0] live_q;
    cwcs_st_e st_q;
    logic [15:0] cnt_q;
    logic [13:0] pend_q;
    logic erase_d_q;
    logic erase_p_q;
    logic hit_cfg;
    logic quarter;

    function automatic logic in_cfg_space(input logic [13:0] a);
        in_cfg_space = (a >= `CWCS_CFG_SPACE_LO) && (a <= `CWCS_CFG_SPACE_HI);
    endfunction

    // Programmer path only; core fetches never see this space
    assign hit_cfg = prog_mode && (prog_addr == `CWCS_CFG_ADDR);
    assign core_cfg_denied = core_cfg_access;
    assign cfg_d = prog_wdata & `CWCS_CFG_IMPL_MASK;

    // Stored word; reset leaves the nonvolatile value intact
    always_ff @(posedge ref_clk) begin
        if (clk_en && st_q == CWCS_ST_WRITE) begin
            cfg_q <= pend_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_q <= CWCS_ST_IDLE;
            cnt_q <= 16'h0;
            pend_q <= `CWCS_CFG_IMPL_MASK;
            erase_d_q <= 1'b0;
            erase_p_q <= 1'b0;
        end else if (clk_en) begin
            case (st_q)
                CWCS_ST_IDLE: begin
                    erase_d_q <= 1'b0;
                    erase_p_q <= 1'b0;
                    if (prog_wr && hit_cfg) begin
                        pend_q <= cfg_d;
                        // Clearing protection wipes the protected array first
                        erase_d_q <= !cfg_q[`CWCS_DPROT_BIT] &&
                            cfg_d[`CWCS_DPROT_BIT];
                        erase_p_q <= !cfg_q[`CWCS_PPROT_BIT] &&
                            cfg_d[`CWCS_PPROT_BIT];
                        cnt_q <= 16'(ERASE_CYC);
                        st_q <= CWCS_ST_ERASE;
                    end
                end
                CWCS_ST_ERASE: begin
                    if (cnt_q <= 16'h1) begin
                        st_q <= CWCS_ST_WRITE;
                    end else begin
                        cnt_q <= cnt_q - 16'h1;
                    end
                end
                CWCS_ST_WRITE: begin
                    erase_d_q <= 1'b0;
                    erase_p_q <= 1'b0;
                    st_q <= CWCS_ST_IDLE;
                end
                default: st_q <= CWCS_ST_IDLE;
            endcase
        end
    end

    assign prog_busy = (st_q != CWCS_ST_IDLE);
    assign erase_data_array = erase_d_q && st_q == CWCS_ST_ERASE;
    assign erase_program_array = erase_p_q && st_q == CWCS_ST_ERASE;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            prog_rdata <= 14'h0;
            prog_rvalid <= 1'b0;
        end else if (clk_en) begin
            prog_rvalid <= prog_rd && prog_mode;
            if (prog_rd && hit_cfg) begin
                prog_rdata <= cfg_q & `CWCS_CFG_IMPL_MASK;
            end else if (prog_rd && in_cfg_space(prog_addr)) begin
                prog_rdata <= 14'h0;
            end
        end
    end

    // Fields captured only while reset is held, frozen afterwards
    always_ff @(posedge ref_clk) begin
        if (clk_en && !rstn) begin
            live_q <= cfg_q & `CWCS_CFG_IMPL_MASK;
        end
    end

    // Trim wiped along with program memory, reloaded by software
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            osc_trim_reg <= `CWCS_TRIM_RESET;
        end else if (clk_en) begin
            if (erase_program_array) begin
                osc_trim_reg <= 8'hFF;
            end else if (sw_trim_wr) begin
                osc_trim_reg <= sw_trim_data;
            end
        end
    end

    assign bandgap_trim = live_q[`CWCS_BG_HI:`CWCS_BG_LO];
    assign data_protect_n = live_q[`CWCS_DPROT_BIT];
    assign program_protect_n = live_q[`CWCS_PPROT_BIT];
    assign brownout_detect_en = live_q[`CWCS_BOD_BIT];
    // Timer follows only its own bit, not brown-out enable
    assign powerup_timer_en = !live_q[`CWCS_POWERUP_TIMER_BIT];
    assign watchdog_en = live_q[`CWCS_WDT_BIT];
    assign osc_select = live_q[`CWCS_OSC_HI:`CWCS_OSC_LO];
    assign reset_pin_as_io = !live_q[`CWCS_RSTPIN_BIT];
    assign core_reset_n = reset_pin_as_io ? 1'b1 : master_reset_pin_n;

    always_comb begin
        case (cwcs_osc_e'(osc_select))
            CWCS_OSC_RC_CLK, CWCS_OSC_RC_IO: clk_source = CWCS_SRC_RC;
            CWCS_OSC_INT_CLK, CWCS_OSC_INT_IO:
                clk_source = CWCS_SRC_INTERNAL;
            CWCS_OSC_EC: clk_source = CWCS_SRC_EXT;
            // Crystal modes also take a driven clock on the input pin
            default: clk_source = CWCS_SRC_CRYSTAL;
        endcase
    end

    assign osc_in_pin_as_io = (clk_source == CWCS_SRC_INTERNAL);
    assign osc_out_pin_as_io = (osc_select == CWCS_OSC_RC_IO) ||
        (osc_select == CWCS_OSC_INT_IO) || (osc_select == CWCS_OSC_EC);
    assign osc_out_clk_en = (osc_select == CWCS_OSC_RC_CLK) ||
        (osc_select == CWCS_OSC_INT_CLK);
    // Oscillator halts while core_reset_n is low (pin used as master reset) in RC or internal modes
    assign internal_rc_osc_run = !(core_reset_n == 1'b0 &&
        (clk_source == CWCS_SRC_RC || clk_source == CWCS_SRC_INTERNAL));

    cwcs_quarter_div u_div (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .run(osc_out_clk_en && internal_rc_osc_run),
        .quarter(quarter)
    );
    assign quarter_clock_out = quarter;
endmodule // cwcs_config_word

// >>> inc/cwcs_defs.svh
// Overview of operation
// - Configuration word sits at 2007h; programmed bits read 0, unprogrammed read 1.
// - Space 2000h-3FFFh is reachable only in programming mode, never by instructions.
// - Bits 13-12 trim bandgap; 00 lowest, 11 highest reference voltage.
// - Bits 11-9 are unimplemented and always read back as zero.
// - Bit 8 low turns data memory protection on; high leaves it off.
// - Turning data protection off erases the whole data EEPROM array.
// - Bit 7 low turns program memory protection on; high leaves it off.
// - Turning program protection off erases program memory including trim word.
// - Bit 6 high enables the brown-out detector, low disables it.
// - Brown-out enable never turns on the power-up timer by itself.
// - Bit 5 high makes pin master reset; low makes it I/O, reset tied high.
// - Master reset asserted in internal or RC mode stops the internal oscillator.
// - Bit 4 high disables the power-up timer, low enables it.
// - Bit 3 high enables the watchdog timer, low disables it.
// - Codes 111/110 select RC oscillator; output pin quarter clock or I/O.
// - Codes 101/100 select internal oscillator, input pin I/O; output clock or I/O.
// - Code 011 takes an external clock on the input pin, output pin I/O.
// - Codes 010/001/000 select fast, standard, low-power crystal, both pins used.
// - Crystal modes also accept an external clock driven onto the input pin.
// - RC and internal modes let output pin be I/O or oscillator divided by four.
// - Trimmed internal oscillator supplies a nominal 4 MHz system clock.
// - Last program word holds return-literal with trim; software loads trim register.
`ifndef CWCS_DEFS_SVH
`define CWCS_DEFS_SVH
`define CWCS_CFG_ADDR 14'h2007
`define CWCS_CFG_SPACE_LO 14'h2000
`define CWCS_CFG_SPACE_HI 14'h3FFF
`define CWCS_CFG_ERASED 14'h3FFF
`define CWCS_CFG_IMPL_MASK 14'h31FF
`define CWCS_BG_HI 13
`define CWCS_BG_LO 12
`define CWCS_DPROT_BIT 8
`define CWCS_PPROT_BIT 7
`define CWCS_BOD_BIT 6
`define CWCS_RSTPIN_BIT 5
`define CWCS_POWERUP_TIMER_BIT 4
`define CWCS_WDT_BIT 3
`define CWCS_OSC_HI 2
`define CWCS_OSC_LO 0
`define CWCS_INTERNAL_RC_OSC_KHZ 4000
`define CWCS_ERASE_NS 2000
`define CWCS_CLK_MHZ 50
`define CWCS_ERASE_CYC ((`CWCS_ERASE_NS * `CWCS_CLK_MHZ + 999) / 1000)
`define CWCS_TRIM_RESET 8'h80
`endif

// >>> inc/cwcs_pkg.sv
package cwcs_pkg;
    typedef enum logic [2:0] {
        CWCS_OSC_LP = 3'b000,
        CWCS_OSC_XT = 3'b001,
        CWCS_OSC_HS = 3'b010,
        CWCS_OSC_EC = 3'b011,
        CWCS_OSC_INT_IO = 3'b100,
        CWCS_OSC_INT_CLK = 3'b101,
        CWCS_OSC_RC_IO = 3'b110,
        CWCS_OSC_RC_CLK = 3'b111
    } cwcs_osc_e;
    typedef enum logic [1:0] {
        CWCS_SRC_CRYSTAL = 2'b00,
        CWCS_SRC_EXT = 2'b01,
        CWCS_SRC_INTERNAL = 2'b10,
        CWCS_SRC_RC = 2'b11
    } cwcs_src_e;
    typedef enum logic [1:0] {
        CWCS_ST_IDLE = 2'b00,
        CWCS_ST_ERASE = 2'b01,
        CWCS_ST_WRITE = 2'b10
    } cwcs_st_e;
endpackage

// >>> design/cwcs_quarter_div.sv
`timescale 1ns/1ps
// Fosc/4 output, one toggle every two enabled cycles
module cwcs_quarter_div (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic run,
    output logic quarter
);
    logic [1:0] cnt_q;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cnt_q <= 2'h0;
        end else if (clk_en) begin
            if (run) begin
                cnt_q <= cnt_q + 2'h1;
            end else begin
                cnt_q <= 2'h0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            quarter <= 1'b0;
        end else if (clk_en) begin
            quarter <= run & cnt_q[1];
        end
    end
endmodule // cwcs_quarter_div

// >>> dv/cwcs_chk.sv
`timescale 1ns/1ps
module cwcs_chk (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic prog_mode,
    input wire logic [13:0] prog_addr,
    input wire logic prog_rd,
    input wire logic [13:0] prog_rdata,
    input wire logic prog_rvalid,
    input wire logic core_cfg_access,
    input wire logic core_cfg_denied,
    input wire logic master_reset_pin_n,
    input wire logic reset_pin_as_io,
    input wire logic core_reset_n,
    input wire logic [2:0] osc_select,
    input wire logic [1:0] clk_source,
    input wire logic internal_rc_osc_run,
    input wire logic osc_in_pin_as_io,
    input wire logic osc_out_pin_as_io,
    input wire logic osc_out_clk_en
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    chk_core_denied: assert property (core_cfg_denied == core_cfg_access)
        else $error("core access to config space not denied");
    chk_reset_pin: assert property (
        core_reset_n == (reset_pin_as_io || master_reset_pin_n))
        else $error("reset pin function wrong");
    chk_osc_stop: assert property (
        !core_reset_n && osc_select[2] |-> !internal_rc_osc_run)
        else $error("oscillator runs in reset");
    chk_in_pin_io: assert property (
        osc_in_pin_as_io == (osc_select[2:1] == 2'b10))
        else $error("input pin function wrong");
    chk_out_pin_io: assert property (
        osc_out_pin_as_io == (osc_select inside {3'h6, 3'h4, 3'h3}))
        else $error("output pin function wrong");
    chk_out_clock: assert property (
        osc_out_clk_en == (osc_select[2] && osc_select[0]))
        else $error("quarter clock enable wrong");
    chk_src_map: assert property (
        clk_source == (osc_select[2] ? {1'b1, osc_select[1]}
        : {1'b0, osc_select == 3'h3}))
        else $error("clock source wrong");
    chk_read_gap: assert property (
        prog_rd && clk_en && prog_mode && prog_addr == 14'h2007
        |=> prog_rvalid && prog_rdata[11:9] == 3'h0)
        else $error("read answer wrong");
    // Fields are captured in reset only, so a late write cannot glitch them
    chk_fields_held: assert property ($past(rstn) |->
        $stable({osc_select, reset_pin_as_io}))
        else $error("fields moved outside reset");
endmodule // cwcs_chk

// >>> dv/cwcs_prog_model.sv
`timescale 1ns/1ps
module cwcs_prog_model (
    input wire logic ref_clk,
    input wire logic prog_busy,
    input wire logic prog_rvalid,
    input wire logic [13:0] prog_rdata,
    output logic prog_mode,
    output logic [13:0] prog_addr,
    output logic [13:0] prog_wdata,
    output logic prog_wr,
    output logic prog_rd
);
    int n;
    initial begin
        prog_mode = 1'b0;
        prog_addr = 14'h0;
        prog_wdata = 14'h0;
        prog_wr = 1'b0;
        prog_rd = 1'b0;
    end
    task automatic start(input logic m, input logic [13:0] a, d);
        @(posedge ref_clk) #1;
        prog_mode = m;
        prog_addr = a;
        prog_wdata = d;
        prog_wr = 1'b1;
        @(posedge ref_clk) #1;
        prog_wr = 1'b0;
        // Released lines show the inverse, not a stale copy
        prog_addr = ~a;
        prog_wdata = ~d;
    endtask
    task automatic finish_wr();
        n = 0;
        while (prog_busy === 1'b1 && n < 200) begin
            @(posedge ref_clk) #1;
            n++;
        end
    endtask
    task automatic rd(output logic [13:0] q);
        @(posedge ref_clk) #1;
        prog_mode = 1'b1;
        prog_addr = 14'h2007;
        prog_rd = 1'b1;
        @(posedge ref_clk) #1;
        q = (prog_rvalid === 1'b1) ? prog_rdata : 'x;
        prog_rd = 1'b0;
        prog_addr = 14'h1FF8;
    endtask
endmodule // cwcs_prog_model

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic ref_clk, rstn, clk_en, prog_mode, prog_wr, prog_rd, prog_rvalid;
    logic prog_busy, core_cfg_access, core_cfg_denied, sw_trim_wr;
    logic erase_data_array, erase_program_array, master_reset_pin_n;
    logic reset_pin_as_io, core_reset_n, data_protect_n, program_protect_n;
    logic brownout_detect_en, powerup_timer_en, watchdog_en;
    logic internal_rc_osc_run, osc_in_pin_as_io, osc_out_pin_as_io;
    logic osc_out_clk_en, quarter_clock_out;
    logic [13:0] prog_addr, prog_wdata, prog_rdata, q, w, fld, dec;
    logic [7:0] sw_trim_data, osc_trim_reg;
    logic [2:0] osc_select;
    logic [1:0] bandgap_trim, clk_source;
    logic [18:0] rows [8];
    int fails, n_tests, i, k;
    assign fld = {bandgap_trim, 3'h0, data_protect_n, program_protect_n,
        brownout_detect_en, !reset_pin_as_io, !powerup_timer_en,
        watchdog_en, osc_select};
    assign dec = {9'h0, clk_source, osc_in_pin_as_io, osc_out_pin_as_io,
        osc_out_clk_en};
    cwcs_config_word #(.ERASE_CYC(4)) u_dut (.*);
    cwcs_prog_model u_prog (.*);
    task automatic tick();
        @(posedge ref_clk) #1;
    endtask
    task automatic rst();
        tick();
        rstn = 1'b0;
        repeat (4) tick();
        rstn = 1'b1;
    endtask
    task automatic wr(input logic [13:0] d);
        u_prog.start(1'b1, 14'h2007, d);
        u_prog.finish_wr();
    endtask
    task automatic cmp(input logic [13:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        #40000;
        fails++;
        close_out();
    end
    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        core_cfg_access = 1'b0;
        sw_trim_wr = 1'b0;
        sw_trim_data = 8'h5A;
        master_reset_pin_n = 1'b1;
        rows = '{{14'h3FF8, 5'h00}, {14'h0E41, 5'h00}, {14'h1992, 5'h00},
            {14'h2173, 5'h0A}, {14'h31EC, 5'h16}, {14'h3FFD, 5'h15},
            {14'h00C6, 5'h1A}, {14'h313F, 5'h19}};
        rst();
        cmp({6'h0, osc_trim_reg}, 14'h0080);
        for (i = 0; i < 8; i++) begin
            wr(rows[i][18:5]);
            rst();
            u_prog.rd(q);
            w = rows[i][18:5] & 14'h31FF;
            cmp(q, w);
            cmp(fld, w);
            cmp(dec, {9'h0, rows[i][4:0]});
            $display("row %0d done", i);
        end
        sw_trim_wr = 1'b1;
        tick();
        sw_trim_wr = 1'b0;
        cmp({6'h0, osc_trim_reg}, 14'h005A);
        u_prog.start(1'b1, 14'h2007, 14'h303F);
        cmp({11'h0, prog_busy, erase_data_array, erase_program_array},
            14'h0004);
        u_prog.finish_wr();
        u_prog.start(1'b1, 14'h2007, 14'h31FD);
        cmp({11'h0, prog_busy, erase_data_array, erase_program_array},
            14'h0007);
        u_prog.finish_wr();
        cmp({6'h0, osc_trim_reg}, 14'h00FF);
        $display("erase test done");
        rst();
        master_reset_pin_n = 1'b0;
        tick();
        cmp({12'h0, core_reset_n, internal_rc_osc_run}, 14'h0);
        master_reset_pin_n = 1'b1;
        tick();
        cmp({12'h0, core_reset_n, internal_rc_osc_run}, 14'h3);
        k = 0;
        q[0] = quarter_clock_out;
        repeat (40) begin
            tick();
            k += int'(quarter_clock_out !== q[0]);
            q[0] = quarter_clock_out;
        end
        cmp(k[13:0], 14'h0014);
        wr(14'h31DD);
        rst();
        master_reset_pin_n = 1'b0;
        tick();
        cmp({13'h0, core_reset_n}, 14'h1);
        $display("reset pin test done");
        u_prog.start(1'b0, 14'h2007, 14'h0000);
        u_prog.finish_wr();
        u_prog.start(1'b1, 14'h2006, 14'h0000);
        u_prog.finish_wr();
        u_prog.rd(q);
        cmp(q, 14'h31DD);
        core_cfg_access = 1'b1;
        tick();
        cmp({13'h0, core_cfg_denied}, 14'h1);
        $display("refusal test done");
        close_out();
    end
endmodule // tb_top
bind cwcs_config_word cwcs_chk u_chk (.*);
